// ===== verilog/pm_throttle_pkg.sv
// Package: offsets, field layouts, reset values, timing constants and carriers
package pm_throttle_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] burst_throttle_count_off  = 8'h48;
    localparam logic [7:0] input_monitor_control_off = 8'h4c;
    localparam logic [7:0] irq_status_off            = 8'h60;
    localparam logic [7:0] irq_mask_off              = 8'h64;
    localparam logic [7:0] monitor_state_off         = 8'h68;
    // Count register fields
    localparam int fast_burst_count_lsb    = 0;
    localparam int pll_lock_res_bit        = 5;
    localparam int pll_lock_count_lsb      = 6;
    localparam int thermal_duty_select_lsb = 11;
    // Monitor control fields
    localparam int input_monitor_enable_lsb  = 0;
    localparam int input_polarity_select_lsb = 13;
    localparam int input_edge_select_mon12   = 26;
    localparam int input_edge_select_mon13   = 27;
    // Reset values and writable masks
    localparam logic [31:0] count_reset   = 32'h0000_0000;
    localparam logic [31:0] count_wmask   = 32'h0000_3fff;
    localparam logic [31:0] monctl_reset  = 32'h0000_0000;
    localparam logic [31:0] monctl_wmask  = 32'h0fff_ffff;
    // Timing: 10 MHz clock
    localparam int clk_hz        = 10_000_000;
    localparam int tick_us_ns    = 1000;
    localparam int tick_ms_ns    = 1_000_000;
    localparam int cyc_per_us    = tick_us_ns / (1_000_000_000 / clk_hz);
    localparam int cyc_per_ms    = tick_ms_ns / (1_000_000_000 / clk_hz);
    // Throttle slot length in cycles; the period is eight slots
    localparam int throttle_slot_cycles = 16;
    localparam int monitors             = 13;
    // Interrupt status bits
    localparam int irq_lock_done = 0;
    localparam int irq_burst_exp = 1;
    localparam int irq_mon_lsb   = 2;

    // Register port request carrier
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;
endpackage

// ===== verilog/input_sync.sv
// Two-stage synchroniser with polarity and edge/level conditioning for one input
`timescale 1ns/1ps
module input_sync
    import pm_throttle_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic pin,
    input  wire logic enable,
    input  wire logic active_low,
    input  wire logic edge_mode,
    output logic      activity
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic act;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;
    logic        lvl;

    // Polarity applied only after the second stage
    always_comb begin
        st_d      = st_q;
        st_d.s1   = pin;
        st_d.s2   = st_q.s1;
        lvl       = st_q.s2 ^ active_low;
        st_d.prev = lvl;
        if (!enable) begin
            st_d.act = 1'b0;
        end else if (edge_mode) begin
            st_d.act = lvl & ~st_q.prev;
        end else begin
            st_d.act = lvl;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign activity = st_q.act;
endmodule

// ===== verilog/pm_throttle_and_input_monitor.sv
// Thermal throttle, fast burst timer and general-purpose input monitor conditioning
// Function
// - Alarm asserted throttles clock by duty field
// - Duty equals stop-clock asserted fraction per period
// - Lock count loads fast burst timer
// - Stop-clock exit loads lock count, lock tick
// - Resolution bit: 0 ms tick, 1 us tick
// - Burst count is initial and reload value
// - Monitor 13 edge or level select
// - Monitor 12 edge or level select
// - Polarity bits per monitor, 1 active low
// - Enable bits gate monitor inputs
// - Fixed input pin to monitor mapping
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module pm_throttle_and_input_monitor
    import pm_throttle_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic        thermal_alarm_n,
    input  wire logic        stop_clock_exit,
    input  wire logic [21:0] gpi,
    output logic             stop_clock_request_n,
    output logic             fast_burst_expired,
    output logic [13:1]      monitor_activity,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef enum logic [2:0] {
        fb_idle  = 3'b001,
        fb_burst = 3'b010,
        fb_lock  = 3'b100
    } fb_mode_t;

    typedef struct packed {
        logic [31:0] count_reg;
        logic [31:0] monctl;
        logic [31:0] status;
        logic [31:0] mask;
        logic [31:0] rdata;
        logic [1:0]  alarm_sync;
        logic [1:0]  exit_sync;
        logic        exit_prev;
        logic [2:0]  slot;
        logic [7:0]  slot_cnt;
        logic        stop_clock_request_n_n;
        fb_mode_t    fb_mode;
        logic [4:0]  fb_count;
        logic [19:0] fb_prescale;
        logic        fb_expired;
        logic [13:1] mon_act;
        logic        irq;
    } state_t;

    state_t      st_q;
    state_t      st_d;
    reg_req_t    req;
    logic [13:1] mon_raw;
    logic [13:1] mon_pin;
    logic [13:1] mon_edge;

    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;

    ////////////////////////////////////////////////////////////////////////////
    // Input to monitor mapping
    assign mon_pin[1]     = gpi[5];
    assign mon_pin[2]     = gpi[6];
    assign mon_pin[3]     = gpi[0];
    assign mon_pin[8:4]   = gpi[17:13];
    assign mon_pin[9]     = gpi[4];
    assign mon_pin[13:10] = gpi[21:18];

    // Only monitors 12 and 13 have an edge select; the rest stay level
    assign mon_edge[11:1] = '0;
    assign mon_edge[12]   = st_q.monctl[input_edge_select_mon12];
    assign mon_edge[13]   = st_q.monctl[input_edge_select_mon13];

    // One conditioner per monitor input
    genvar g;
    generate
        for (g = 1; g <= monitors; g++) begin : g_mon
            input_sync u_sync (
                .ref_clk    (ref_clk),
                .rst        (rst),
                .pin        (mon_pin[g]),
                .enable     (st_q.monctl[input_monitor_enable_lsb + g - 1]),
                .active_low (st_q.monctl[input_polarity_select_lsb + g - 1]),
                .edge_mode  (mon_edge[g]),
                .activity   (mon_raw[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic [2:0]  duty;
        logic        exit_edge;
        logic        tick;
        logic [19:0] tick_len;
        logic [31:0] events;
        duty      = st_q.count_reg[thermal_duty_select_lsb +: 3];
        exit_edge = 1'b0;
        tick      = 1'b0;
        tick_len  = '0;
        events    = '0;
        st_d      = st_q;

        // Pin synchronisers; first stage feeds only the second
        st_d.alarm_sync = {st_q.alarm_sync[0], thermal_alarm_n};
        st_d.exit_sync  = {st_q.exit_sync[0], stop_clock_exit};
        st_d.exit_prev  = st_q.exit_sync[1];
        exit_edge       = st_q.exit_sync[1] & ~st_q.exit_prev;

        // Throttle period: eight slots, stop-clock held for duty slots
        if (st_q.slot_cnt == 8'(throttle_slot_cycles - 1)) begin
            st_d.slot_cnt = '0;
            st_d.slot     = st_q.slot + 3'h1;
        end else begin
            st_d.slot_cnt = st_q.slot_cnt + 8'h01;
        end
        // Code 000 is reserved; treated as no throttling
        if (!st_q.alarm_sync[1] && duty != 3'h0) begin
            st_d.stop_clock_request_n_n = ~(st_d.slot < duty);
        end else begin
            st_d.stop_clock_request_n_n = 1'b1;
        end

        // Fast burst timer tick select
        if (st_q.fb_mode == fb_lock && !st_q.count_reg[pll_lock_res_bit]) begin
            tick_len = 20'(cyc_per_ms);
        end else begin
            tick_len = 20'(cyc_per_us);
        end
        if (st_q.fb_prescale >= tick_len - 20'h1) begin
            st_d.fb_prescale = '0;
            tick             = 1'b1;
        end else begin
            st_d.fb_prescale = st_q.fb_prescale + 20'h1;
        end

        st_d.fb_expired = 1'b0;
        case (st_q.fb_mode)
            fb_idle: begin
                st_d.fb_mode  = fb_burst;
                st_d.fb_count = st_q.count_reg[fast_burst_count_lsb +: 5];
            end
            fb_burst: begin
                if (tick) begin
                    if (st_q.fb_count == 5'h0) begin
                        st_d.fb_count   = st_q.count_reg[fast_burst_count_lsb +: 5];
                        st_d.fb_expired = 1'b1;
                        events[irq_burst_exp] = 1'b1;
                    end else begin
                        st_d.fb_count = st_q.fb_count - 5'h1;
                    end
                end
            end
            fb_lock: begin
                if (tick) begin
                    if (st_q.fb_count == 5'h0) begin
                        st_d.fb_mode  = fb_burst;
                        st_d.fb_count = st_q.count_reg[fast_burst_count_lsb +: 5];
                        events[irq_lock_done] = 1'b1;
                    end else begin
                        st_d.fb_count = st_q.fb_count - 5'h1;
                    end
                end
            end
            default: begin
                st_d.fb_mode = fb_idle;
            end
        endcase
        // Processor leaving stop clock starts the lock measurement
        if (exit_edge) begin
            st_d.fb_mode     = fb_lock;
            st_d.fb_count    = st_q.count_reg[pll_lock_count_lsb +: 5];
            st_d.fb_prescale = '0;
        end

        st_d.mon_act = mon_raw;
        events[irq_mon_lsb +: monitors] = mon_raw;

        // Register writes; reserved count and control bits never stored, mask stored whole
        if (req.wr) begin
            case (req.addr)
                burst_throttle_count_off:
                    st_d.count_reg = req.wdata & count_wmask;
                input_monitor_control_off:
                    st_d.monctl = req.wdata & monctl_wmask;
                irq_mask_off:
                    st_d.mask = req.wdata;
                default: ;
            endcase
        end

        // Read data one cycle later; status clears on read, new events win
        st_d.rdata = '0;
        if (req.rd) begin
            case (req.addr)
                burst_throttle_count_off:  st_d.rdata = st_q.count_reg;
                input_monitor_control_off: st_d.rdata = st_q.monctl;
                irq_status_off: begin
                    st_d.rdata  = st_q.status;
                    st_d.status = '0;
                end
                irq_mask_off:      st_d.rdata = st_q.mask;
                monitor_state_off: st_d.rdata = {18'h0, st_q.mon_act, 1'b0};
                default:           st_d.rdata = '0;
            endcase
        end
        st_d.status = st_d.status | events;
        st_d.irq    = |(st_d.status & st_d.mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q            <= '0;
            st_q.count_reg  <= count_reset;
            st_q.monctl     <= monctl_reset;
            st_q.alarm_sync <= 2'h3;
            st_q.stop_clock_request_n_n   <= 1'b1;
            st_q.fb_mode    <= fb_idle;
        end else begin
            st_q <= st_d;
        end
    end

    // All outputs straight from flip-flops
    assign reg_rdata            = st_q.rdata;
    assign stop_clock_request_n = st_q.stop_clock_request_n_n;
    assign fast_burst_expired   = st_q.fb_expired;
    assign monitor_activity     = st_q.mon_act;
    assign irq                  = st_q.irq;
endmodule

// ===== verif/pm_throttle_checker.sv
// Port checker for the throttle and input monitor block
`timescale 1ns/1ps
module pm_throttle_checker
    import pm_throttle_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        thermal_alarm_n,
    input wire logic        stop_clock_request_n,
    input wire logic        fast_burst_expired,
    input wire logic [13:1] monitor_activity,
    input wire logic        irq
);
    logic [31:0] cnt_q;
    logic [31:0] ctl_q;
    logic [31:0] msk_q;
    logic [3:0]  age_q;
    ////////////////////////////////////////////////////////////////////////
    // Shadow settings; age lets the design settle after a write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 32'h0;
            ctl_q <= 32'h0;
            msk_q <= 32'h0;
            age_q <= 4'h0;
        end else begin
            age_q <= (age_q == 4'hf) ? age_q : age_q + 4'h1;
            if (reg_wr) age_q <= 4'h0;
            if (reg_wr && reg_addr == burst_throttle_count_off) cnt_q <= reg_wdata;
            if (reg_wr && reg_addr == input_monitor_control_off) ctl_q <= reg_wdata;
            if (reg_wr && reg_addr == irq_mask_off) msk_q <= reg_wdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    property p_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read slot");
    property p_rsv_cnt; s_rd(burst_throttle_count_off) |=> reg_rdata[31:14] == 18'h0; endproperty
    a_rsv_cnt: assert property (p_rsv_cnt) else $error("count reserved bits set");
    property p_ctl_rb;
        s_rd(input_monitor_control_off) |=> reg_rdata == ($past(ctl_q) & monctl_wmask);
    endproperty
    a_ctl_rb: assert property (p_ctl_rb) else $error("monitor control readback");
    property p_pulse; fast_burst_expired |=> !fast_burst_expired; endproperty
    a_pulse: assert property (p_pulse) else $error("burst pulse too long");
    property p_duty0; cnt_q[13:11] == 3'h0 && age_q == 4'hf |-> stop_clock_request_n; endproperty
    a_duty0: assert property (p_duty0) else $error("stop clock with zero duty");
    property p_no_alarm; thermal_alarm_n [*6] |-> stop_clock_request_n; endproperty
    a_no_alarm: assert property (p_no_alarm) else $error("stop clock without alarm");
    property p_enable; age_q == 4'hf |-> (monitor_activity & ~ctl_q[12:0]) == 13'h0; endproperty
    a_enable: assert property (p_enable) else $error("disabled monitor active");
    property p_edge;
        age_q == 4'hf && ctl_q[27] && monitor_activity[13] |=> !monitor_activity[13];
    endproperty
    a_edge: assert property (p_edge) else $error("edge monitor not a pulse");
    property p_irq_off; age_q == 4'hf && msk_q == 32'h0 |-> !irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while all masked");
endmodule
bind pm_throttle_and_input_monitor pm_throttle_checker u_chk (.ref_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .thermal_alarm_n, .stop_clock_request_n,
    .fast_burst_expired, .monitor_activity, .irq);

// ===== verif/cpu_stop_model.sv
// Processor side model: counts cycles the stop-clock request is held
`timescale 1ns/1ps
module cpu_stop_model (
    input wire logic ref_clk,
    input wire logic clear,
    input wire logic stop_clock_request_n,
    output int       low_count
);
    // Stopped cycles since clear; caller compares over whole periods
    always @(posedge ref_clk) begin
        if (clear) low_count <= 0;
        else if (!stop_clock_request_n) low_count <= low_count + 1;
    end
endmodule

// ===== verif/pm_throttle_and_input_monitor_tb.sv
// Self-checking bench for the throttle and input monitor block
`timescale 1ns/1ps
module pm_throttle_and_input_monitor_tb;
    import pm_throttle_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        thermal_alarm_n = 1'b1;
    logic        stop_clock_exit = 1'b0;
    logic [21:0] gpi = 22'h0;
    logic        clear = 1'b0;
    logic        stop_clock_request_n, fast_burst_expired, irq;
    logic [13:1] monitor_activity;
    logic [31:0] reg_rdata, v;
    int          errors = 0;
    int          checks_done = 0;
    int          low_count, t0, t1, span;
    int          pin_of [13] = '{5, 6, 0, 13, 14, 15, 16, 17, 4, 18, 19, 20, 21};
    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;
    pm_throttle_and_input_monitor dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .thermal_alarm_n, .stop_clock_exit, .gpi,
        .stop_clock_request_n, .fast_burst_expired, .monitor_activity, .irq);
    cpu_stop_model peer (.ref_clk, .clear, .stop_clock_request_n, .low_count);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Ends just past an edge so outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    // Cycles between two expiry pulses; watchdog guards a hang
    task automatic gap(output int n);
        realtime t;
        @(posedge fast_burst_expired);
        t = $realtime;
        @(posedge fast_burst_expired);
        n = int'(($realtime - t) / 100.0);
    endtask
    task automatic print_verdict;
        if (errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the tests need under 16000 cycles, most of it one ms tick
    initial begin
        cyc(40000);
        errors++;
        print_verdict();
    end
    // Main sequence
    initial begin
        cyc(3);
        @(posedge ref_clk) rst <= 1'b0;
        rd(burst_throttle_count_off);
        chk(v, 32'h0);
        rd(input_monitor_control_off);
        chk(v, 32'h0);
        wr(burst_throttle_count_off, 32'hffff_ffff);
        wr(input_monitor_control_off, 32'hffff_ffff);
        wr(8'h70, 32'hffff_ffff);
        rd(burst_throttle_count_off);
        chk(v, 32'h0000_3fff);
        rd(input_monitor_control_off);
        chk(v, 32'h0fff_ffff);
        rd(8'h70);
        chk(v, 32'h0);
        wr(input_monitor_control_off, 32'h0000_1fff);
        for (int m = 1; m <= 13; m++) begin
            @(posedge ref_clk) gpi <= 22'h1 << pin_of[m-1];
            cyc(6);
            chk(32'({monitor_activity, 1'b0}), 32'h1 << m);
        end
        @(posedge ref_clk) gpi <= 22'h0;
        wr(input_monitor_control_off, 32'h0000_2001);
        cyc(6);
        chk(32'(monitor_activity), 32'h1);
        @(posedge ref_clk) gpi <= 22'h3f_ffff;
        wr(input_monitor_control_off, 32'h0);
        cyc(6);
        chk(32'(monitor_activity), 32'h0);
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk) gpi <= 22'h0;
            wr(input_monitor_control_off, (32'h1 << (26 + k)) | (32'h1 << (11 + k)));
            cyc(6);
            @(posedge ref_clk) gpi[20 + k] <= 1'b1;
            span = 0;
            repeat (12) begin
                cyc(1);
                span += int'(monitor_activity[12 + k]);
            end
            chk(span, 1);
        end
        @(posedge ref_clk) gpi <= 22'h0;
        wr(input_monitor_control_off, 32'h1);
        wr(irq_mask_off, 32'h4);
        rd(irq_status_off);
        cyc(2);
        chk(irq, 1'b0);
        @(posedge ref_clk) gpi[5] <= 1'b1;
        cyc(6);
        chk(irq, 1'b1);
        rd(monitor_state_off);
        chk(v, 32'h2);
        @(posedge ref_clk) gpi[5] <= 1'b0;
        cyc(6);
        chk(irq, 1'b1);
        rd(irq_status_off);
        chk(v & 32'h4, 32'h4);
        cyc(2);
        chk(irq, 1'b0);
        // Burst gap difference hides the tick alignment of the reload
        wr(burst_throttle_count_off, 32'h0000_0223);
        gap(t0);
        wr(burst_throttle_count_off, 32'h0000_0226);
        gap(t1);
        chk(t1 - t0, 3 * cyc_per_us);
        rd(irq_status_off);
        wr(irq_mask_off, 32'h1);
        // Lock count 8 at 1 us: done nine ticks after the synchronised edge
        @(posedge ref_clk) stop_clock_exit <= 1'b1;
        cyc(85);
        chk(irq, 1'b0);
        cyc(10);
        chk(irq, 1'b1);
        @(posedge ref_clk) stop_clock_exit <= 1'b0;
        // Lock count 0 at 1 ms: one whole millisecond tick before done
        wr(burst_throttle_count_off, 32'h0);
        rd(irq_status_off);
        @(posedge ref_clk) stop_clock_exit <= 1'b1;
        cyc(9000);
        chk(irq, 1'b0);
        cyc(1100);
        chk(irq, 1'b1);
        @(posedge ref_clk) stop_clock_exit <= 1'b0;
        wr(irq_mask_off, 32'h0);
        for (int d = 0; d < 8; d++) begin
            wr(burst_throttle_count_off, 32'(d) << 11);
            @(posedge ref_clk) thermal_alarm_n <= 1'b0;
            cyc(12);
            @(posedge ref_clk) clear <= 1'b1;
            @(posedge ref_clk) clear <= 1'b0;
            cyc(256);
            chk(low_count, d * 32);
            @(posedge ref_clk) thermal_alarm_n <= 1'b1;
        end
        print_verdict();
    end
endmodule
